// *** rtl/bclt_top.v ***
`timescale 1ns/100ps
`include "bclt_regs.vh"

module bclt_top (
    // clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // avalon-mm slave
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // back-channel mode decode
    output wire        bc_high_speed,
    output wire        bc_spi_mode,
    output wire        bc_spi_reverse,
    output wire [2:0]  bc_gpio_count,
    // spi pins
    input  wire        spi_sclk,
    input  wire        spi_select,
    input  wire        spi_mosi,
    output wire        spi_miso_o,
    output wire        spi_miso_oe_n,
    // spi core side
    input  wire [7:0]  spi_tx_byte,
    input  wire        spi_tx_load,
    output wire [7:0]  spi_rx_byte,
    output wire        spi_rx_valid,
    // adaptive equalizer control
    output wire        eq_adapt_skip,
    output wire [5:0]  eq_manual_setting,
    output wire        eq_adapt_restart,
    output wire        eq_start_level_use,
    output wire [3:0]  eq_start_level_p0,
    output wire [3:0]  eq_start_level_p1,
    // loop-through
    input  wire        link_input_zero,
    input  wire        link_input_one,
    output wire        loopthrough_output,
    output wire        loopthrough_drive_on
);

    // software-visible registers
    reg  [7:0]  port_sel_r;
    reg  [7:0]  eq_ctl_r;
    reg  [7:0]  mode_ctl_r;
    reg  [7:0]  eq_manual_r;
    reg  [7:0]  floor_p0_r;
    reg  [7:0]  floor_p1_r;
    reg  [7:0]  lt_sel_a_r;
    reg  [7:0]  lt_enable_r;
    reg  [7:0]  lt_sel_b_r;

    // bus handshake and read path
    reg         ack_r;
    reg  [31:0] rdata_r;
    reg  [7:0]  rd_nxt;

    // decoded back-channel mode, registered value and next value
    reg         hs_r;
    reg         spi_r;
    reg         rev_r;
    reg  [2:0]  gpio_r;
    reg         hs_nxt;
    reg         spi_nxt;
    reg         rev_nxt;
    reg  [2:0]  gpio_nxt;

    // registered equalizer setting and loop-through state
    reg  [5:0]  eq_set_r;
    reg         lt_data_r;
    reg         lt_drive_r;

    // address decode and helpers shared between processes
    wire [7:0]  idx;
    wire        wr_go;
    wire        wr_lo;
    wire        second_port;
    wire        lt_src;
    wire        lt_mismatch;
    wire        sel_seen;
    wire [1:0]  lt_src_code;
    wire [7:0]  status_byte;

    // word index and qualified write strobes
    assign idx         = avs_address[9:2];
    assign wr_go       = avs_write & ack_r;
    assign wr_lo       = wr_go & avs_byteenable[0];

    // bank select and loop-through source bit
    assign second_port = port_sel_r[`BCLT_BIT_SECOND_PORT];
    assign lt_src      = lt_sel_a_r[`BCLT_BIT_LT_SRC];

    // one wait state: the request completes on the second edge
    // read data come from a flip-flop loaded on the first edge, so a
    // read cannot finish earlier; writes take the same two cycles so
    // that software sees a single timing for every access
    always @(posedge clk_sys) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // low in the second cycle of a request and while idle,
    // and never for more than one cycle per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    // register writes, low byte lane only, unmapped indices ignored
    // reserved bits are kept as written, so reads return them unchanged;
    // the floor register is banked, so software sets the port select
    // first and leaves it alone until the floor access has finished
    always @(posedge clk_sys) begin
        if (!nrst) begin
            port_sel_r  <= `BCLT_RST_PORT_SEL;
            eq_ctl_r    <= `BCLT_RST_EQ_CTL;
            mode_ctl_r  <= `BCLT_RST_MODE_CTL;
            eq_manual_r <= `BCLT_RST_EQ_MANUAL;
            floor_p0_r  <= `BCLT_RST_EQ_FLOOR;
            floor_p1_r  <= `BCLT_RST_EQ_FLOOR;
            lt_sel_a_r  <= `BCLT_RST_LT_SEL_A;
            lt_enable_r <= `BCLT_RST_LT_ENABLE;
            lt_sel_b_r  <= `BCLT_RST_LT_SEL_B;
        end else if (wr_lo) begin
            case (idx)
                `BCLT_IDX_PORT_SEL: begin
                    port_sel_r <= avs_writedata[7:0];
                end
                `BCLT_IDX_EQ_CTL: begin
                    eq_ctl_r <= avs_writedata[7:0];
                end
                `BCLT_IDX_MODE_CTL: begin
                    mode_ctl_r <= avs_writedata[7:0];
                end
                `BCLT_IDX_EQ_MANUAL: begin
                    eq_manual_r <= avs_writedata[7:0];
                end
                // floor writes land in the bank that the port select names
                `BCLT_IDX_EQ_FLOOR: begin
                    if (second_port) begin
                        floor_p1_r <= avs_writedata[7:0];
                    end else begin
                        floor_p0_r <= avs_writedata[7:0];
                    end
                end
                `BCLT_IDX_LT_SEL_A: begin
                    lt_sel_a_r <= avs_writedata[7:0];
                end
                `BCLT_IDX_LT_ENABLE: begin
                    lt_enable_r <= avs_writedata[7:0];
                end
                `BCLT_IDX_LT_SEL_B: begin
                    lt_sel_b_r <= avs_writedata[7:0];
                end
                // status and unmapped indices take no writes
                default: ;
            endcase
        end
    end

    // read mux, unmapped indices read zero
    // the floor read follows the same bank as the floor write
    always @* begin
        case (idx)
            `BCLT_IDX_PORT_SEL: rd_nxt = port_sel_r;
            `BCLT_IDX_EQ_CTL: rd_nxt = eq_ctl_r;
            `BCLT_IDX_MODE_CTL: rd_nxt = mode_ctl_r;
            `BCLT_IDX_EQ_MANUAL: rd_nxt = eq_manual_r;
            `BCLT_IDX_EQ_FLOOR: rd_nxt = second_port ? floor_p1_r : floor_p0_r;
            `BCLT_IDX_LT_SEL_A: rd_nxt = lt_sel_a_r;
            `BCLT_IDX_LT_ENABLE: rd_nxt = lt_enable_r;
            `BCLT_IDX_LT_SEL_B: rd_nxt = lt_sel_b_r;
            // status bits are read-only; writes to this index are ignored
            `BCLT_IDX_STATUS: rd_nxt = status_byte;
            default: rd_nxt = 8'h00;
        endcase
    end

    // read data captured in the wait cycle, stands while waitrequest is low
    // upper bits are always zero; each register is eight bits wide
    // a write leaves the last read byte in place
    always @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= {24'h00_0000, rd_nxt};
        end
    end

    // read data output straight from its flip-flop
    assign avs_readdata = rdata_r;

    // back-channel mode decode
    // codes 000-011 carry gpios over the back channel, 100-111 carry spi;
    // the gpio count is zero in normal-frame gpio mode and in every spi mode
    always @* begin
        hs_nxt   = 1'b0;
        spi_nxt  = 1'b0;
        rev_nxt  = 1'b0;
        gpio_nxt = 3'h0;
        case (mode_ctl_r[2:0])
            `BCLT_MODE_NORM_GPIO: gpio_nxt = 3'h0;
            `BCLT_MODE_HS_GPIO1: begin
                hs_nxt   = 1'b1;
                gpio_nxt = 3'h1;
            end
            `BCLT_MODE_HS_GPIO2: begin
                hs_nxt   = 1'b1;
                gpio_nxt = 3'h2;
            end
            `BCLT_MODE_HS_GPIO4: begin
                hs_nxt   = 1'b1;
                gpio_nxt = 3'h4;
            end
            `BCLT_MODE_NORM_FSPI: spi_nxt = 1'b1;
            `BCLT_MODE_NORM_RSPI: begin
                spi_nxt = 1'b1;
                rev_nxt = 1'b1;
            end
            `BCLT_MODE_HS_FSPI: begin
                hs_nxt  = 1'b1;
                spi_nxt = 1'b1;
            end
            `BCLT_MODE_HS_RSPI: begin
                hs_nxt  = 1'b1;
                spi_nxt = 1'b1;
                rev_nxt = 1'b1;
            end
            // all eight codes are listed; the default only guards against x
            default: gpio_nxt = 3'h0;
        endcase
    end

    // registered mode and equalizer outputs
    // registering the decode keeps a half-written mode off the link;
    // every output here moves one cycle after the write that sets it
    always @(posedge clk_sys) begin
        if (!nrst) begin
            hs_r     <= 1'b0;
            spi_r    <= 1'b0;
            rev_r    <= 1'b0;
            gpio_r   <= 3'h0;
            eq_set_r <= `BCLT_RST_EQ_SETTING;
        end else begin
            hs_r     <= hs_nxt;
            spi_r    <= spi_nxt;
            rev_r    <= rev_nxt;
            gpio_r   <= gpio_nxt;
            eq_set_r <= {eq_manual_r[7:5], eq_manual_r[3:1]};
        end
    end

    // mode outputs straight from their flip-flops
    assign bc_high_speed      = hs_r;
    assign bc_spi_mode        = spi_r;
    assign bc_spi_reverse     = rev_r;
    assign bc_gpio_count      = gpio_r;

    // equalizer controls: bypass, manual setting, restart and start level
    assign eq_adapt_skip      = eq_manual_r[`BCLT_BIT_ADAPT_SKIP];
    assign eq_manual_setting  = eq_set_r;
    assign eq_adapt_restart   = eq_ctl_r[`BCLT_BIT_EQ_RESTART];
    assign eq_start_level_use = eq_ctl_r[`BCLT_BIT_LVL_OVRD] &
                                eq_ctl_r[`BCLT_BIT_LVL_APPLY];

    // start levels of both ports; only the low four bits are used
    assign eq_start_level_p0  = floor_p0_r[3:0];
    assign eq_start_level_p1  = floor_p1_r[3:0];

    // source selects must agree; the status bit shows when they do not
    // a mismatch is not supported: bit 7 still decides the route, and
    // the mismatch bit only lets software see that the two disagree
    assign lt_src_code = lt_src ? `BCLT_LT_FIELD_PORT1 : `BCLT_LT_FIELD_PORT0;
    assign lt_mismatch = (lt_sel_b_r[2:1] != lt_src_code);

    // status byte: driver on, select seen and source mismatch
    assign status_byte = {5'h00, lt_drive_r, sel_seen, lt_mismatch};

    // loop-through data, held low while the driver is off
    // forcing the data low keeps a disabled driver from passing on the
    // last link bit when it is enabled again; enable and data move together
    always @(posedge clk_sys) begin
        if (!nrst) begin
            lt_data_r  <= 1'b0;
            lt_drive_r <= 1'b0;
        end else begin
            // the drive flag follows the enable bit one cycle later
            lt_drive_r <= lt_enable_r[`BCLT_BIT_LT_DRIVE];
            if (lt_enable_r[`BCLT_BIT_LT_DRIVE]) begin
                lt_data_r <= lt_src ? link_input_one : link_input_zero;
            end else begin
                lt_data_r <= 1'b0;
            end
        end
    end

    // loop-through outputs straight from their flip-flops
    assign loopthrough_output   = lt_data_r;
    assign loopthrough_drive_on = lt_drive_r;

    // spi data-out path, active only in reverse spi modes
    // the port takes the raw pins and synchronises them itself; the
    // float bit and polarity come straight from the mode register
    bclt_spi_port u_spi (
        // clock and reset
        .clk_sys               (clk_sys),
        .nrst                  (nrst),
        // pins
        .spi_sclk              (spi_sclk),
        .spi_select            (spi_select),
        .spi_mosi              (spi_mosi),
        .spi_miso_o            (spi_miso_o),
        .spi_miso_oe_n         (spi_miso_oe_n),
        // configuration from the mode register
        .port_active           (rev_r),
        .miso_float            (mode_ctl_r[`BCLT_BIT_MISO_FLOAT]),
        .serial_clock_polarity (mode_ctl_r[`BCLT_BIT_CLK_POL]),
        // core side
        .tx_byte               (spi_tx_byte),
        .tx_load               (spi_tx_load),
        .rx_byte               (spi_rx_byte),
        .rx_valid              (spi_rx_valid),
        .select_seen           (sel_seen)
    );

endmodule // bclt_top

// *** rtl/bclt_regs.vh ***
`ifndef BCLT_REGS_VH
`define BCLT_REGS_VH

// register indices, byte address is four times the index
`define BCLT_IDX_PORT_SEL    8'h34
`define BCLT_IDX_EQ_CTL      8'h35
`define BCLT_IDX_MODE_CTL    8'h43
`define BCLT_IDX_EQ_MANUAL   8'h44
`define BCLT_IDX_EQ_FLOOR    8'h45
`define BCLT_IDX_LT_SEL_A    8'h52
`define BCLT_IDX_LT_ENABLE   8'h56
`define BCLT_IDX_LT_SEL_B    8'h57
`define BCLT_IDX_STATUS      8'h5f

// reset values
`define BCLT_RST_PORT_SEL    8'h00
`define BCLT_RST_EQ_CTL      8'h00
`define BCLT_RST_MODE_CTL    8'h00
`define BCLT_RST_EQ_MANUAL   8'h60
`define BCLT_RST_EQ_FLOOR    8'h88
`define BCLT_RST_LT_SEL_A    8'h00
`define BCLT_RST_LT_ENABLE   8'h00
`define BCLT_RST_LT_SEL_B    8'h00
`define BCLT_RST_EQ_SETTING  6'h18

// field positions
`define BCLT_BIT_SECOND_PORT 1
`define BCLT_BIT_EQ_RESTART  6
`define BCLT_BIT_LVL_OVRD    5
`define BCLT_BIT_LVL_APPLY   4
`define BCLT_BIT_MISO_FLOAT  4
`define BCLT_BIT_CLK_POL     3
`define BCLT_BIT_ADAPT_SKIP  0
`define BCLT_BIT_LT_SRC      7
`define BCLT_BIT_LT_DRIVE    3

// back-channel mode codes
`define BCLT_MODE_NORM_GPIO  3'h0
`define BCLT_MODE_HS_GPIO1   3'h1
`define BCLT_MODE_HS_GPIO2   3'h2
`define BCLT_MODE_HS_GPIO4   3'h3
`define BCLT_MODE_NORM_FSPI  3'h4
`define BCLT_MODE_NORM_RSPI  3'h5
`define BCLT_MODE_HS_FSPI    3'h6
`define BCLT_MODE_HS_RSPI    3'h7

// loop-through source field codes
`define BCLT_LT_FIELD_PORT0  2'h1
`define BCLT_LT_FIELD_PORT1  2'h2

`endif

// *** rtl/bclt_spi_port.v ***
`timescale 1ns/100ps
`include "bclt_regs.vh"

module bclt_spi_port (
    // clock and reset
    input  wire       clk_sys,
    input  wire       nrst,
    // spi pins
    input  wire       spi_sclk,
    input  wire       spi_select,
    input  wire       spi_mosi,
    output wire       spi_miso_o,
    output wire       spi_miso_oe_n,
    // configuration
    input  wire       port_active,
    input  wire       miso_float,
    input  wire       serial_clock_polarity,
    // core side
    input  wire [7:0] tx_byte,
    input  wire       tx_load,
    output wire [7:0] rx_byte,
    output wire       rx_valid,
    output wire       select_seen
);

    reg  [1:0] sclk_sync_r;
    reg  [1:0] sel_sync_r;
    reg  [1:0] mosi_sync_r;
    reg        sclk_prev_r;
    reg  [7:0] tx_sh_r;
    reg  [7:0] rx_sh_r;
    reg  [2:0] bit_cnt_r;
    reg  [7:0] rx_byte_r;
    reg        rx_valid_r;
    reg        miso_r;
    wire       rise;
    wire       fall;
    wire       launch;
    wire       capture;

    // pin synchronisers, second stage feeds all logic
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sclk_sync_r <= 2'h0;
            sel_sync_r  <= 2'h0;
            mosi_sync_r <= 2'h0;
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], spi_sclk};
            sel_sync_r  <= {sel_sync_r[0], spi_select};
            mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
            sclk_prev_r <= sclk_sync_r[1];
        end
    end

    assign rise    = sclk_sync_r[1] & ~sclk_prev_r;
    assign fall    = ~sclk_sync_r[1] & sclk_prev_r;
    assign launch  = serial_clock_polarity ? rise : fall;
    assign capture = serial_clock_polarity ? fall : rise;

    // shift out on launch edge, shift in on capture edge
    always @(posedge clk_sys) begin
        if (!nrst) begin
            tx_sh_r    <= 8'h00;
            rx_sh_r    <= 8'h00;
            bit_cnt_r  <= 3'h0;
            rx_byte_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            miso_r     <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (tx_load) begin
                tx_sh_r <= tx_byte;
                miso_r  <= tx_byte[7];
            end else if (launch && sel_sync_r[1]) begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                miso_r  <= tx_sh_r[6];
            end
            if (!sel_sync_r[1]) begin
                bit_cnt_r <= 3'h0;                             // frame ends with select
            end else if (capture) begin
                rx_sh_r   <= {rx_sh_r[6:0], mosi_sync_r[1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    rx_byte_r  <= {rx_sh_r[6:0], mosi_sync_r[1]};
                    rx_valid_r <= 1'b1;
                end
            end
        end
    end

    // while the port is active, the driver floats when idle only if software asked for it
    assign spi_miso_oe_n = ~(port_active & (~miso_float | sel_sync_r[1]));
    assign spi_miso_o    = miso_r;
    assign rx_byte       = rx_byte_r;
    assign rx_valid      = rx_valid_r;
    assign select_seen   = sel_sync_r[1];

endmodule // bclt_spi_port

// *** verification/bclt_top_props.sv ***
`timescale 1ns/100ps
module bclt_top_props (
    // clock and reset
    input logic       clk_sys,
    input logic       nrst,
    // bus handshake
    input logic       avs_write,
    input logic       avs_waitrequest,
    // mode decode
    input logic       bc_high_speed,
    input logic       bc_spi_mode,
    input logic       bc_spi_reverse,
    input logic [2:0] bc_gpio_count,
    // watched outputs and link inputs
    input logic       spi_miso_oe_n,
    input logic [5:0] eq_manual_setting,
    input logic [3:0] eq_start_level_p0,
    input logic       link_input_zero,
    input logic       link_input_one,
    input logic       loopthrough_output,
    input logic       loopthrough_drive_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // a write completes on the edge where waitrequest is low
    wire wr_ack = avs_write & ~avs_waitrequest;

    // gpio count follows the mode code
    AST_GPIO_COUNT: assert property (!bc_spi_mode |-> (bc_high_speed ?
        bc_gpio_count inside {3'h1, 3'h2, 3'h4} : bc_gpio_count == 3'h0))
        else $error("gpio count wrong for mode");
    AST_REV_IS_SPI: assert property (bc_spi_reverse |-> bc_spi_mode)
        else $error("reverse without spi mode");
    AST_SPI_NO_GPIO: assert property (bc_spi_mode |-> bc_gpio_count == 3'h0)
        else $error("gpio count in spi mode");
    AST_MISO_DRIVE: assert property (!spi_miso_oe_n |-> bc_spi_reverse)
        else $error("miso driven outside reverse spi");
    // settings move only after a completed write
    AST_MANUAL_HOLD: assert property ($changed(eq_manual_setting) |->
        $past(wr_ack) || $past(wr_ack, 2)) else $error("manual setting moved");
    AST_FLOOR_HOLD: assert property ($changed(eq_start_level_p0) |->
        $past(wr_ack) || $past(wr_ack, 2)) else $error("floor moved");
    AST_LT_OFF: assert property (!loopthrough_drive_on |-> !loopthrough_output)
        else $error("loop-through active while off");
    AST_LT_SOURCE: assert property (loopthrough_output |->
        $past(link_input_zero) || $past(link_input_one)) else $error("loop-through no source");

    // main scenarios
    COV_WRITE: cover property (wr_ack);
    COV_LT_ON: cover property (loopthrough_drive_on && loopthrough_output);
    COV_REV: cover property (bc_spi_reverse && !spi_miso_oe_n);
endmodule // bclt_top_props

bind bclt_top bclt_top_props u_props (.clk_sys, .nrst, .avs_write, .avs_waitrequest,
    .bc_high_speed, .bc_spi_mode, .bc_spi_reverse, .bc_gpio_count, .spi_miso_oe_n,
    .eq_manual_setting, .eq_start_level_p0, .link_input_zero, .link_input_one,
    .loopthrough_output, .loopthrough_drive_on);

// *** verification/bclt_top_test.sv ***
`timescale 1ns/100ps
module bclt_top_test;
    logic        clk_sys, nrst, avs_read, avs_write, spi_sclk, spi_select, spi_mosi;
    logic        spi_tx_load, link_input_zero, link_input_one;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [7:0]  spi_tx_byte, q;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, bc_high_speed, bc_spi_mode, bc_spi_reverse, spi_miso_o;
    wire         spi_miso_oe_n, spi_rx_valid, eq_adapt_skip, eq_adapt_restart;
    wire         eq_start_level_use, loopthrough_output, loopthrough_drive_on;
    wire  [2:0]  bc_gpio_count;
    wire  [7:0]  spi_rx_byte;
    wire  [5:0]  eq_manual_setting;
    wire  [3:0]  eq_start_level_p0, eq_start_level_p1;
    int          failures, n_checks, n_valid;
    // rows: mode code, high speed, spi, reverse, gpio count
    logic [8:0]  rows [8] = '{9'b000_000_000, 9'b001_100_001, 9'b010_100_010,
        9'b011_100_100, 9'b100_010_000, 9'b101_011_000, 9'b110_110_000, 9'b111_111_000};

    bclt_top i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .bc_high_speed, .bc_spi_mode,
        .bc_spi_reverse, .bc_gpio_count, .spi_sclk, .spi_select, .spi_mosi, .spi_miso_o,
        .spi_miso_oe_n, .spi_tx_byte, .spi_tx_load, .spi_rx_byte, .spi_rx_valid,
        .eq_adapt_skip, .eq_manual_setting, .eq_adapt_restart, .eq_start_level_use,
        .eq_start_level_p0, .eq_start_level_p1, .link_input_zero, .link_input_one,
        .loopthrough_output, .loopthrough_drive_on);

    // clock generation
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // count receive strobes, one expected per byte
    always @(posedge clk_sys) if (spi_rx_valid === 1'b1) n_valid++;

    // compare and count
    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), q, exp);
    endtask

    task settle;
        repeat (4) @(posedge clk_sys);
    endtask

    // one spi byte; miso sampled just before each capture edge
    task spi_xfer(input logic pol, input logic [7:0] tx, input logic [7:0] mo);
        logic [7:0] seen;
        n_valid = 0;
        spi_sclk <= pol;
        spi_tx_byte <= tx;
        spi_tx_load <= 1'b1;
        @(posedge clk_sys);
        spi_tx_load <= 1'b0;
        spi_select <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            spi_mosi <= mo[i];
            repeat (8) @(posedge clk_sys);
            seen[i] = spi_miso_o;
            spi_sclk <= !pol;
            repeat (8) @(posedge clk_sys);
            spi_sclk <= pol;
        end
        repeat (8) @(posedge clk_sys);
        spi_select <= 1'b0;
        chk("spi miso", seen, tx);
        chk("spi rx", spi_rx_byte, mo);
        chk("spi valid", n_valid, 32'd1);
    endtask

    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        summarize;
    end

    // main sequence
    initial begin
        {nrst, avs_read, avs_write, spi_sclk, spi_select, spi_mosi, spi_tx_load} = '0;
        {link_input_zero, link_input_one, avs_address, avs_writedata, spi_tx_byte} = '0;
        avs_byteenable = 4'h1;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdc(8'h44, 8'h60);
        rdc(8'h45, 8'h88);
        rdc(8'h52, 8'h00);
        rdc(8'h56, 8'h00);
        rdc(8'h57, 8'h00);
        chk("manual", eq_manual_setting, 6'h18);
        chk("skip", eq_adapt_skip, 1'b0);
        chk("floor p0", eq_start_level_p0, 4'h8);
        chk("drive on", loopthrough_drive_on, 1'b0);
        // every mode code, miso float off
        foreach (rows[i]) begin
            bus(1'b1, 8'h43, {5'h0, rows[i][8:6]});
            settle;
            chk("mode decode", {bc_high_speed, bc_spi_mode, bc_spi_reverse}, rows[i][5:3]);
            chk("gpio count", bc_gpio_count, rows[i][2:0]);
            chk("miso oe", spi_miso_oe_n, !rows[i][3]);
        end
        bus(1'b1, 8'h5f, 8'h5a);
        rdc(8'h5f, 8'h01);
        // manual equalizer setting and bypass
        bus(1'b1, 8'h44, 8'ha5);
        settle;
        chk("manual", eq_manual_setting, 6'b101010);
        chk("skip", eq_adapt_skip, 1'b1);
        // banked floor and its enables
        bus(1'b1, 8'h45, 8'h03);
        bus(1'b1, 8'h34, 8'h02);
        bus(1'b1, 8'h45, 8'h0c);
        rdc(8'h45, 8'h0c);
        bus(1'b1, 8'h35, 8'h20);
        settle;
        chk("floor p0", eq_start_level_p0, 4'h3);
        chk("floor p1", eq_start_level_p1, 4'hc);
        chk("use", eq_start_level_use, 1'b0);
        bus(1'b1, 8'h35, 8'h70);
        settle;
        chk("use", eq_start_level_use, 1'b1);
        chk("restart", eq_adapt_restart, 1'b1);
        // loop-through routing and enable
        bus(1'b1, 8'h57, 8'h02);
        bus(1'b1, 8'h56, 8'h08);
        link_input_zero <= 1'b1;
        settle;
        chk("lt port0", loopthrough_output, 1'b1);
        chk("drive on", loopthrough_drive_on, 1'b1);
        bus(1'b1, 8'h52, 8'h80);
        bus(1'b1, 8'h57, 8'h04);
        settle;
        chk("lt port1 low", loopthrough_output, 1'b0);
        rdc(8'h5f, 8'h04);
        link_input_one <= 1'b1;
        settle;
        chk("lt port1", loopthrough_output, 1'b1);
        bus(1'b1, 8'h56, 8'h00);
        settle;
        chk("lt off", loopthrough_output, 1'b0);
        // float while unselected, then transfers in both polarities
        bus(1'b1, 8'h43, 8'h15);
        settle;
        chk("miso float", spi_miso_oe_n, 1'b1);
        spi_select <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("miso selected", spi_miso_oe_n, 1'b0);
        spi_select <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, 8'h43, {4'h0, p[0], 3'h5});
            spi_xfer(p[0], p ? 8'h96 : 8'ha5, p ? 8'h5a : 8'h3c);
        end
        // second reset in mid-run
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdc(8'h44, 8'h60);
        rdc(8'h43, 8'h00);
        summarize;
    end
endmodule // bclt_top_test
